// [rtl/interrupt_controller_unit.sv]
// Interrupt and exception front end: capture, arbitration, vector offer
//
// Operation
// - Forty-six requests: two non-maskable and forty-four maskable, plus reset, exceptions.
// - A pending exception is offered before any pending interrupt.
// - Thirty-two traps; codes 0040h plus index, handlers 40h or 50h by group.
// - Illegal opcode trap uses code 0060h and handler 00000060h.
// - Every maskable request has a programmable priority of eight levels.
// - Service starts no sooner than five clocks after the request.
// - Reset from pin or watchdog uses code 0000h, handler 0, no return.
// - Pin NMI code 0010h handler 10h; watchdog NMI code 0020h handler 20h.
// - Maskable sources are internal peripheral requests plus six external pins.
// - Each maskable request has its own mask; masked ones are never acknowledged.
// - Nesting allowed only when the new level beats the level in service.
// - Each external pin has selectable valid edges; only such an edge requests.
// - Watchdog maskable is slot 0, converter end slot 1; handler equals code.
// - Two timer overflows and six capture/compares take slots 2 to 9.
// - Six pin edge requests take slots 10 to 15 in pin order.
// - Two CAN channels, four requests each, take slots 16 to 23.
// - Three clocked serial, then two async serial channels take slots 24 to 32.
// - Capture timers take slots 33 to 38, eight-bit timers 39 to 43.
// - Among equal candidates the lower default slot number wins.
// - Pin NMI is served before watchdog NMI, which stays pending.
// - Acknowledging a maskable request enters the interrupts-disabled state.
`timescale 1ns/1ps
`include "irq_consts.svh"
module interrupt_controller_unit (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  // Reset sources
  input  wire logic                        reset_pin_n,
  input  wire logic                        wdt_reset_req,
  // Non-maskable sources
  input  wire logic                        nmi_pin,
  input  wire logic                        nmi_rise_en,
  input  wire logic                        nmi_fall_en,
  input  wire logic                        watchdog_nonmaskable_request,
  // Maskable sources and their control
  input  wire logic [`N_INTERNAL-1:0]      periph_req,
  input  wire logic [`N_PIN-1:0]           ext_pin,
  input  wire logic [`N_PIN-1:0]           pin_rise_en,
  input  wire logic [`N_PIN-1:0]           pin_fall_en,
  input  wire logic [`N_MASK-1:0]          mask_en,
  input  wire logic [`N_MASK*`LVL_W-1:0]   prio_lvl,
  // Exceptions from the core
  input  wire logic                        trap_req,
  input  wire logic [4:0]                  trap_index,
  input  wire logic                        illegal_opcode_trap,
  input  wire logic [31:0]                 following_instruction_address,
  // Core handshake
  input  wire logic                        core_take,
  input  wire logic                        core_reti,
  input  wire logic                        core_ei,
  // Vector to the core
  output logic                             vec_valid,
  output irq_pkg::vkind_t                  vec_kind,
  output logic [15:0]                      vec_code,
  output logic [31:0]                      vec_handler,
  output logic [31:0]                      vec_return,
  // Controller state
  output logic                             int_disabled,
  output logic                             nmi_in_service
);

  arb_if arb ();

  // Pin synchronisers; only the second stage and later are read
  logic                    rst_s1_q, rst_s2_q;
  logic                    nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic [`N_PIN-1:0]       pin_s1_q, pin_s2_q, pin_s3_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      rst_s1_q <= reset_pin_n;
      rst_s2_q <= rst_s1_q;
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      pin_s1_q <= ext_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Edge selection; with both enables low a pin raises nothing
  wire              nmi_edge = (nmi_rise_en & nmi_s2_q & ~nmi_s3_q) |
                               (nmi_fall_en & ~nmi_s2_q & nmi_s3_q);
  wire [`N_PIN-1:0] pin_edge = (pin_rise_en & pin_s2_q & ~pin_s3_q) |
                               (pin_fall_en & ~pin_s2_q & pin_s3_q);

  // Slot map: pins sit between the timer and CAN groups
  wire [`N_MASK-1:0] mask_raw = {periph_req[`N_INTERNAL-1:`PIN_BASE],
                                 pin_edge,
                                 periph_req[`PIN_BASE-1:0]};
  wire [`N_EVT-1:0]  evt_in   = {watchdog_nonmaskable_request, nmi_edge,
                                 mask_raw};

  // Delay line keeps every interrupt out of service for the least latency
  logic [`DLY_STAGES-1:0][`N_EVT-1:0] dly_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[`DLY_STAGES-2:0], evt_in};
    end
  end
  wire [`N_EVT-1:0] evt_late = dly_q[`DLY_STAGES-1];

  // Pending flags and service state
  irq_pkg::vstate_t      st_q, st_d;
  logic [`N_MASK-1:0]    pend_q;
  logic                  nmip_q, wdtp_q, rstp_q, ilgp_q, trpp_q;
  logic [4:0]            trap_n_q;
  logic                  id_q, np_q;
  logic [`N_LVL-1:0]     isr_q;
  logic [`IDX_W-1:0]     off_idx_q;
  logic [`LVL_W-1:0]     off_lvl_q;
  irq_pkg::vkind_t       kind_q;
  logic [15:0]           code_q;
  logic [31:0]           hnd_q, ret_q;

  // Level in service: the lowest set bit is the most urgent one running
  logic [`LVL_W-1:0] cur_lvl;
  always_comb begin
    cur_lvl = '1;
    for (int l = `N_LVL - 1; l >= 0; l--) begin
      if (isr_q[l]) begin
        cur_lvl = l[`LVL_W-1:0];
      end
    end
  end

  // Arbitration among unmasked pending maskable requests
  assign arb.req = pend_q & ~mask_en;
  assign arb.lvl = prio_lvl;

  wire nest_ok  = (isr_q == '0) || (arb.win_lvl < cur_lvl);
  wire mask_ok  = arb.found && !id_q && !np_q && nest_ok;
  wire exc_any  = ilgp_q || trpp_q;
  wire nmi_ok   = nmip_q && !np_q;
  wire wdt_ok   = wdtp_q && !np_q;

  // Selection order: reset, exceptions, pin NMI, watchdog NMI, maskable
  wire take_rst = rstp_q;
  wire take_ilg = !take_rst && ilgp_q;
  wire take_trp = !take_rst && !ilgp_q && trpp_q;
  wire take_nmi = !take_rst && !exc_any && nmi_ok;
  wire take_wdt = !take_rst && !exc_any && !nmi_ok && wdt_ok;
  wire take_msk = !take_rst && !exc_any && !nmi_ok && !wdt_ok && mask_ok;
  wire sel_any  = take_rst | take_ilg | take_trp | take_nmi | take_wdt |
                  take_msk;

  irq_pkg::vkind_t sel_kind;
  assign sel_kind = take_rst ? irq_pkg::KIND_RESET :
                    take_ilg ? irq_pkg::KIND_ILLEGAL_OPCODE_TRAP :
                    take_trp ? irq_pkg::KIND_TRAP  :
                    take_nmi ? irq_pkg::KIND_NMI   :
                    take_wdt ? irq_pkg::KIND_WDT   : irq_pkg::KIND_MASK;

  wire [15:0] mask_code = `CODE_MASK_BASE + {6'h00, arb.idx, 4'h0};
  wire [15:0] trap_code = `CODE_TRAP_BASE + {11'h000, trap_n_q};
  wire [31:0] trap_hnd  = trap_n_q[4] ? `HND_TRAP_HIGH : `HND_TRAP_LOW;

  wire [15:0] sel_code  = take_rst ? `CODE_RESET   :
                          take_ilg ? `CODE_ILLEGAL_OPCODE_TRAP   :
                          take_trp ? trap_code     :
                          take_nmi ? `CODE_NMI     :
                          take_wdt ? `CODE_WDT_NMI : mask_code;
  // Handlers equal the code zero-extended, traps excepted
  wire [31:0] sel_hnd   = take_trp ? trap_hnd : {16'h0000, sel_code};
  wire [31:0] sel_ret   = take_rst ? `RET_RESET
                                   : following_instruction_address;

  // An offered maskable vector is withdrawn if masked meanwhile
  wire withdraw = (st_q == irq_pkg::ST_OFFER) &&
                  (kind_q == irq_pkg::KIND_MASK) && mask_en[off_idx_q];
  wire accept   = (st_q == irq_pkg::ST_OFFER) && core_take && !withdraw;
  wire acc_msk  = accept && (kind_q == irq_pkg::KIND_MASK);
  wire acc_nmi  = accept && (kind_q == irq_pkg::KIND_NMI);
  wire acc_wdt  = accept && (kind_q == irq_pkg::KIND_WDT);

  // Source clear on acceptance; a new event in the same cycle wins
  wire [`N_MASK-1:0] clr_vec = acc_msk ? (`N_MASK'(1) << off_idx_q) : '0;
  wire [`N_MASK-1:0] pend_d  = (pend_q & ~clr_vec) | evt_late[`N_MASK-1:0];
  wire               rst_evt = !rst_s2_q || wdt_reset_req;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      irq_pkg::ST_IDLE: begin
        if (sel_any) begin
          st_d = irq_pkg::ST_OFFER;
        end
      end
      irq_pkg::ST_OFFER: begin
        if (accept || withdraw) begin
          st_d = irq_pkg::ST_IDLE;
        end
      end
      default: st_d = irq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= irq_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_q <= '0;
      nmip_q <= 1'b0;
      wdtp_q <= 1'b0;
      rstp_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      nmip_q <= evt_late[`N_EVT-2] | (nmip_q & ~acc_nmi);
      wdtp_q <= evt_late[`N_EVT-1] | (wdtp_q & ~acc_wdt);
      rstp_q <= rst_evt |
                (rstp_q & ~(accept && kind_q == irq_pkg::KIND_RESET));
    end
  end

  // Exceptions are synchronous to the core and need no latency delay
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ilgp_q   <= 1'b0;
      trpp_q   <= 1'b0;
      trap_n_q <= '0;
    end else begin
      ilgp_q <= illegal_opcode_trap |
                (ilgp_q & ~(accept && kind_q == irq_pkg::KIND_ILLEGAL_OPCODE_TRAP));
      trpp_q <= trap_req |
                (trpp_q & ~(accept && kind_q == irq_pkg::KIND_TRAP));
      if (trap_req) begin
        trap_n_q <= trap_index;
      end
    end
  end

  // Interrupt disable, NMI service and in-service levels
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      id_q  <= 1'b0;
      np_q  <= 1'b0;
      isr_q <= '0;
    end else begin
      if (acc_msk || acc_nmi || acc_wdt) begin
        id_q <= 1'b1;
      end else if (core_ei) begin
        id_q <= 1'b0;
      end
      if (acc_nmi || acc_wdt) begin
        np_q <= 1'b1;
      end else if (core_reti && np_q) begin
        np_q <= 1'b0;
      end
      if (acc_msk) begin
        isr_q <= isr_q | (`N_LVL'(1) << off_lvl_q);
      end else if (core_reti && !np_q && isr_q != '0) begin
        isr_q <= isr_q & ~(`N_LVL'(1) << cur_lvl);
      end
    end
  end

  // Vector captured on entry to the offer and held until it ends
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      kind_q    <= irq_pkg::KIND_RESET;
      code_q    <= '0;
      hnd_q     <= '0;
      ret_q     <= '0;
      off_idx_q <= '0;
      off_lvl_q <= '0;
    end else if (st_q == irq_pkg::ST_IDLE && sel_any) begin
      kind_q    <= sel_kind;
      code_q    <= sel_code;
      hnd_q     <= sel_hnd;
      ret_q     <= sel_ret;
      off_idx_q <= arb.idx;
      off_lvl_q <= arb.win_lvl;
    end
  end

  mask_level_arbiter u_arb (
    .a (arb.arbiter)
  );

  assign vec_valid      = (st_q == irq_pkg::ST_OFFER);
  assign vec_kind       = kind_q;
  assign vec_code       = code_q;
  assign vec_handler    = hnd_q;
  assign vec_return     = ret_q;
  assign int_disabled   = id_q;
  assign nmi_in_service = np_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  wire quiet = (st_q == irq_pkg::ST_IDLE) && (dly_q == '0) &&
               (pend_q == '0) && !nmip_q && !wdtp_q && !rstp_q &&
               !ilgp_q && !trpp_q && !rst_evt && !illegal_opcode_trap &&
               !trap_req;

  sequence s_quiet_req;
    quiet && (|evt_in);
  endsequence

  sequence s_no_offer;
    !vec_valid [*5];
  endsequence

  AST_MIN_LATENCY: assert property (s_quiet_req |-> s_no_offer)
    else $error("interrupt offered before five clocks");

  AST_MASKED_NO_ACK: assert property (acc_msk |-> !mask_en[off_idx_q])
    else $error("masked request acknowledged");

  AST_DI_AFTER_ACK: assert property (acc_msk |=> id_q && !vec_valid)
    else $error("interrupts not disabled after acknowledge");

  AST_NMI_ORDER: assert property (
    st_q == irq_pkg::ST_IDLE && nmip_q && wdtp_q && !np_q && !rstp_q &&
    !exc_any |=> vec_kind == irq_pkg::KIND_NMI && wdtp_q)
    else $error("watchdog NMI served before pin NMI");

  AST_EXC_FIRST: assert property (
    st_q == irq_pkg::ST_IDLE && exc_any && !rstp_q && (|pend_q) |=>
    vec_kind inside {irq_pkg::KIND_ILLEGAL_OPCODE_TRAP, irq_pkg::KIND_TRAP})
    else $error("interrupt served before exception");

  AST_MASK_VECTOR: assert property (
    vec_valid && vec_kind == irq_pkg::KIND_MASK |->
    vec_code == 16'(`CODE_MASK_BASE + {6'h00, off_idx_q, 4'h0}) &&
    vec_handler == {16'h0000, vec_code})
    else $error("maskable vector mismatch");

  AST_TRAP_VECTOR: assert property (
    vec_valid && vec_kind == irq_pkg::KIND_TRAP |->
    vec_code[15:5] == 11'h002 &&
    vec_handler == (vec_code[4] ? `HND_TRAP_HIGH : `HND_TRAP_LOW))
    else $error("trap vector mismatch");

  AST_ILLEGAL_OPCODE_TRAP_VECTOR: assert property (
    vec_valid && vec_kind == irq_pkg::KIND_ILLEGAL_OPCODE_TRAP |->
    vec_code == `CODE_ILLEGAL_OPCODE_TRAP && vec_handler == 32'h00000060)
    else $error("illegal opcode vector mismatch");

  AST_RESET_VECTOR: assert property (
    vec_valid && vec_kind == irq_pkg::KIND_RESET |->
    vec_code == `CODE_RESET && vec_handler == 32'h00000000)
    else $error("reset vector mismatch");

  AST_NEST_LEVEL: assert property (
    st_q == irq_pkg::ST_IDLE && take_msk && isr_q != '0 |->
    arb.win_lvl < cur_lvl)
    else $error("nested request without higher level");

  AST_OFFER_HOLD: assert property (
    vec_valid && !accept && !withdraw |=> vec_valid && $stable(vec_code) &&
    $stable(vec_return))
    else $error("offered vector changed before acceptance");

endmodule : interrupt_controller_unit

// [rtl/irq_consts.svh]
// Constants of the interrupt and exception front end
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// Source counts and widths
`define N_MASK          44
`define N_INTERNAL      38
`define N_PIN           6
`define N_EVT           46
`define PIN_BASE        10
`define LVL_W           3
`define IDX_W           6
`define N_LVL           8

// Least request-to-service latency in system clocks
`define MIN_LAT_CYC     5
`define DLY_STAGES      4

// Default-priority slots of the maskable groups
`define SRC_WDT_MASK    6'h00
`define SRC_CONV_END    6'h01
`define SRC_GTIMER      6'h02
`define SRC_PIN         6'h0a
`define SRC_CAN         6'h10
`define SRC_CSI         6'h18
`define SRC_UART        6'h1b
`define SRC_CTIMER      6'h21
`define SRC_TM8         6'h27

// Exception codes and handler addresses
`define CODE_RESET      16'h0000
`define CODE_NMI        16'h0010
`define CODE_WDT_NMI    16'h0020
`define CODE_TRAP_BASE  16'h0040
`define CODE_ILLEGAL_OPCODE_TRAP      16'h0060
`define CODE_MASK_BASE  16'h0080
`define HND_TRAP_LOW    32'h00000040
`define HND_TRAP_HIGH   32'h00000050
`define RET_RESET       32'h00000000

`endif

// [rtl/irq_pkg.sv]
// Types of the interrupt and exception front end
package irq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_OFFER = 2'b10
  } vstate_t;

  typedef enum logic [5:0] {
    KIND_RESET = 6'b000001,
    KIND_ILLEGAL_OPCODE_TRAP = 6'b000010,
    KIND_TRAP  = 6'b000100,
    KIND_NMI   = 6'b001000,
    KIND_WDT   = 6'b010000,
    KIND_MASK  = 6'b100000
  } vkind_t;

endpackage : irq_pkg

// [rtl/arb_if.sv]
// Request and winner signals between controller and level arbiter
`timescale 1ns/1ps
`include "irq_consts.svh"
interface arb_if;
  logic [`N_MASK-1:0]             req;
  logic [`N_MASK-1:0][`LVL_W-1:0] lvl;
  logic                           found;
  logic [`IDX_W-1:0]              idx;
  logic [`LVL_W-1:0]              win_lvl;

  modport arbiter (input req, input lvl,
                   output found, output idx, output win_lvl);
  modport user    (output req, output lvl,
                   input found, input idx, input win_lvl);
endinterface : arb_if

// [rtl/mask_level_arbiter.sv]
// Picks the best unmasked maskable request by level, then default order
`timescale 1ns/1ps
`include "irq_consts.svh"
module mask_level_arbiter (
  arb_if.arbiter a
);
  logic              found_v;
  logic [`IDX_W-1:0] idx_v;
  logic [`LVL_W-1:0] lvl_v;

  // Walk downward so that on equal levels the lower index is kept
  always_comb begin
    found_v = 1'b0;
    idx_v   = '0;
    lvl_v   = '1;
    for (int i = `N_MASK - 1; i >= 0; i--) begin
      if (a.req[i] && (!found_v || a.lvl[i] <= lvl_v)) begin
        found_v = 1'b1;
        idx_v   = i[`IDX_W-1:0];
        lvl_v   = a.lvl[i];
      end
    end
  end

  assign a.found   = found_v;
  assign a.idx     = idx_v;
  assign a.win_lvl = lvl_v;
endmodule : mask_level_arbiter

// [tb/core_model.sv]
// Processor core model: accepts offered vectors after a chosen delay
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  // Vector offered by the controller
  input  wire logic            vec_valid,
  input  wire irq_pkg::vkind_t vec_kind,
  input  wire logic [15:0]     vec_code,
  input  wire logic [31:0]     vec_handler,
  input  wire logic [31:0]     vec_return,
  // Acceptance control
  input  wire logic [1:0]      take_dly,
  output logic                 core_take,
  // Record of the last accepted vector
  output logic [15:0]          acc_cnt,
  output irq_pkg::vkind_t      acc_kind,
  output logic [15:0]          acc_code,
  output logic [31:0]          acc_hnd,
  output logic [31:0]          acc_ret
);
  logic [1:0] wait_q;

  initial core_take = 1'b0;

  // Take moves only at the falling edge so it is steady when sampled
  always @(negedge mclk) begin
    core_take <= 1'b0;
    if (sys_rst || !vec_valid || core_take) begin
      wait_q <= 2'h0;
    end else if (wait_q >= take_dly) begin
      core_take <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // Counted whenever take meets a valid offer, even one withdrawn in that cycle
  always @(posedge mclk) begin
    if (sys_rst) begin
      acc_cnt <= 16'h0000;
    end else if (vec_valid && core_take) begin
      acc_cnt  <= acc_cnt + 16'h0001;
      acc_kind <= vec_kind;
      acc_code <= vec_code;
      acc_hnd  <= vec_handler;
      acc_ret  <= vec_return;
    end
  end
endmodule : core_model

// [tb/testbench.sv]
// Self-checking bench of the interrupt and exception front end
`timescale 1ns/1ps
`include "irq_consts.svh"
module testbench;
  logic                      mclk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      reset_pin_n = 1'b1;
  logic                      wdt_reset_req = 1'b0;
  logic                      nmi_pin = 1'b0;
  logic                      nmi_rise_en = 1'b1;
  logic                      nmi_fall_en = 1'b0;
  logic                      wdt_nmi = 1'b0;
  logic [`N_INTERNAL-1:0]    periph_req = '0;
  logic [`N_PIN-1:0]         ext_pin = '0;
  logic [`N_PIN-1:0]         pin_rise_en = '1;
  logic [`N_PIN-1:0]         pin_fall_en = '1;
  logic [`N_MASK-1:0]        mask_en = '0;
  logic [`N_MASK*`LVL_W-1:0] prio_lvl = '0;
  logic                      trap_req = 1'b0;
  logic [4:0]                trap_index = 5'h00;
  logic                      ilg = 1'b0;
  logic [31:0]               ret_addr = 32'h00000000;
  logic                      core_reti = 1'b0;
  logic                      core_ei = 1'b0;
  logic [1:0]                take_dly = 2'h0;
  logic                      core_take;
  logic                      vec_valid;
  logic                      int_disabled;
  logic                      nmi_in_service;
  irq_pkg::vkind_t           vec_kind;
  irq_pkg::vkind_t           acc_kind;
  logic [15:0]               vec_code;
  logic [15:0]               acc_code;
  logic [15:0]               acc_cnt;
  logic [31:0]               vec_handler;
  logic [31:0]               vec_return;
  logic [31:0]               acc_hnd;
  logic [31:0]               acc_ret;
  int                        error_cnt = 0;
  int                        n_checks = 0;
  int                        seed = 32'hf680;

  always #12.5 mclk = ~mclk;

  interrupt_controller_unit i_dut (
    .mclk, .sys_rst, .reset_pin_n, .wdt_reset_req, .nmi_pin, .nmi_rise_en,
    .nmi_fall_en, .watchdog_nonmaskable_request(wdt_nmi), .periph_req,
    .ext_pin, .pin_rise_en, .pin_fall_en, .mask_en, .prio_lvl, .trap_req,
    .trap_index, .illegal_opcode_trap(ilg),
    .following_instruction_address(ret_addr), .core_take, .core_reti,
    .core_ei, .vec_valid, .vec_kind, .vec_code, .vec_handler, .vec_return,
    .int_disabled, .nmi_in_service
  );

  core_model i_core (
    .mclk, .sys_rst, .vec_valid, .vec_kind, .vec_code, .vec_handler,
    .vec_return, .take_dly, .core_take, .acc_cnt, .acc_kind, .acc_code,
    .acc_hnd, .acc_ret
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction : rnd

  function automatic logic [15:0] mcode(input int s);
    return `CODE_MASK_BASE + 16'(s << 4);
  endfunction : mcode

  // Pins are toggled, so each call makes exactly one edge
  task automatic set_req(input int s);
    if (s < `PIN_BASE) periph_req[s] = 1'b1;
    else if (s < `PIN_BASE + `N_PIN) ext_pin[s-`PIN_BASE] = ~ext_pin[s-`PIN_BASE];
    else periph_req[s-`N_PIN] = 1'b1;
  endtask : set_req

  task automatic strobe();
    @(negedge mclk);
    {periph_req, trap_req, ilg, wdt_nmi, wdt_reset_req, core_ei, core_reti} = '0;
  endtask : strobe

  task automatic ctl(input logic r, input logic e);
    core_reti = r;
    core_ei = e;
    strobe();
  endtask : ctl

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge mclk);
      chk(vec_valid, 1'b0);
    end
  endtask : quiet

  task automatic take_vec(input logic [15:0] code, input logic [31:0] hnd,
                          input logic [31:0] ret, input irq_pkg::vkind_t kind,
                          input logic fin);
    logic [15:0] c0;
    int          k;
    c0 = acc_cnt;
    k = 0;
    while (acc_cnt === c0 && k < 80) begin
      @(negedge mclk);
      k++;
    end
    chk(acc_cnt, c0 + 16'h0001);
    chk(acc_kind, kind);
    chk(acc_code, code);
    chk(acc_hnd, hnd);
    chk(acc_ret, ret);
    if (fin) ctl(1'b1, 1'b1);
  endtask : take_vec

  task automatic mvec(input int s, input logic fin);
    take_vec(mcode(s), {16'h0000, mcode(s)}, ret_addr, irq_pkg::KIND_MASK, fin);
  endtask : mvec

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Over ten times the expected run length
  initial begin
    #(25 * 20000);
    error_cnt++;
    end_of_test();
  end

  initial begin
    int a, b, la, lb, w;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    ret_addr = $random(seed);
    set_req(0);
    strobe();
    quiet(4);
    @(negedge mclk);
    chk(vec_valid, 1'b1);
    mvec(0, 1'b0);
    chk(int_disabled, 1'b1);
    ctl(1'b1, 1'b1);
    $display("test latency finished");
    for (int s = 0; s < `N_MASK; s++) begin
      ret_addr = $random(seed);
      take_dly = 2'($random(seed));
      set_req(s);
      strobe();
      mvec(s, 1'b0);
      chk(int_disabled, 1'b1);
      ctl(1'b1, 1'b1);
    end
    $display("test sweep finished");
    for (int i = 0; i < 20; i++) begin
      a = rnd(38);
      b = (a + 1 + rnd(37)) % 38;
      if (a >= `PIN_BASE) a += `N_PIN;
      if (b >= `PIN_BASE) b += `N_PIN;
      la = rnd(8);
      lb = rnd(8);
      prio_lvl[a*`LVL_W +: `LVL_W] = la[2:0];
      prio_lvl[b*`LVL_W +: `LVL_W] = lb[2:0];
      set_req(a);
      set_req(b);
      strobe();
      w = (la < lb || (la == lb && a < b)) ? a : b;
      mvec(w, 1'b1);
      mvec(w == a ? b : a, 1'b1);
    end
    prio_lvl = '0;
    $display("test priority finished");
    mask_en[5] = 1'b1;
    pin_rise_en[2] = 1'b0;
    pin_fall_en[2] = 1'b0;
    set_req(5);
    set_req(`PIN_BASE + 2);
    strobe();
    quiet(15);
    mask_en[5] = 1'b0;
    mvec(5, 1'b1);
    quiet(15);
    // Masking a standing offer must drop it before the slow core takes it
    take_dly = 2'h3;
    set_req(6);
    strobe();
    repeat (5) @(negedge mclk);
    chk(vec_valid, 1'b1);
    mask_en[6] = 1'b1;
    quiet(3);
    mask_en[6] = 1'b0;
    mvec(6, 1'b1);
    pin_rise_en = '1;
    pin_fall_en = '1;
    $display("test mask finished");
    prio_lvl[3*`LVL_W +: `LVL_W] = 3'h3;
    prio_lvl[4*`LVL_W +: `LVL_W] = 3'h5;
    prio_lvl[7*`LVL_W +: `LVL_W] = 3'h1;
    set_req(3);
    strobe();
    mvec(3, 1'b0);
    ctl(1'b0, 1'b1);
    set_req(4);
    strobe();
    quiet(15);
    set_req(7);
    strobe();
    mvec(7, 1'b0);
    ctl(1'b1, 1'b1);
    quiet(12);
    ctl(1'b1, 1'b1);
    mvec(4, 1'b1);
    prio_lvl = '0;
    $display("test nesting finished");
    for (int i = 0; i < 32; i++) begin
      trap_index = 5'(i);
      trap_req = 1'b1;
      strobe();
      take_vec(16'h0040 + 16'(i), i < 16 ? 32'h00000040 : 32'h00000050,
               ret_addr, irq_pkg::KIND_TRAP, 1'b1);
    end
    set_req(2);
    strobe();
    mvec(2, 1'b0);
    ctl(1'b1, 1'b0);
    set_req(1);
    strobe();
    repeat (8) @(negedge mclk);
    // Exception and freed maskable become eligible on the same edge
    ilg = 1'b1;
    core_ei = 1'b1;
    strobe();
    take_vec(16'h0060, 32'h00000060, ret_addr, irq_pkg::KIND_ILLEGAL_OPCODE_TRAP, 1'b1);
    mvec(1, 1'b1);
    $display("test exceptions finished");
    nmi_pin = 1'b1;
    strobe();
    take_vec(16'h0010, 32'h00000010, ret_addr, irq_pkg::KIND_NMI, 1'b0);
    chk(nmi_in_service, 1'b1);
    wdt_nmi = 1'b1;
    strobe();
    quiet(12);
    ctl(1'b1, 1'b0);
    take_vec(16'h0020, 32'h00000020, ret_addr, irq_pkg::KIND_WDT, 1'b1);
    // Pin edge and watchdog pulse reach the delay line on one edge
    nmi_pin = 1'b0;
    repeat (4) @(negedge mclk);
    nmi_pin = 1'b1;
    repeat (2) @(negedge mclk);
    wdt_nmi = 1'b1;
    strobe();
    take_vec(16'h0010, 32'h00000010, ret_addr,
             irq_pkg::KIND_NMI, 1'b0);
    chk(nmi_in_service, 1'b1);
    ctl(1'b1, 1'b0);
    take_vec(16'h0020, 32'h00000020, ret_addr,
             irq_pkg::KIND_WDT, 1'b1);
    $display("test nonmaskable finished");
    wdt_reset_req = 1'b1;
    strobe();
    take_vec(16'h0000, 32'h00000000, 32'h00000000, irq_pkg::KIND_RESET, 1'b1);
    reset_pin_n = 1'b0;
    @(negedge mclk);
    reset_pin_n = 1'b1;
    take_vec(16'h0000, 32'h00000000, 32'h00000000, irq_pkg::KIND_RESET, 1'b1);
    $display("test reset vector finished");
    end_of_test();
  end
endmodule : testbench
